// ### verilog/pic_consts.vh
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------------
`define PIC_FLAG_A      8'h00
`define PIC_FLAG_B      8'h04
`define PIC_FLAG_C      8'h08
`define PIC_EN_A        8'h0c
`define PIC_EN_B        8'h10
`define PIC_EN_C        8'h14
`define PIC_PRIO_BASE   8'h18
`define PIC_PRIO_LAST   8'h44
`define PIC_EXC_CTRL    8'h48
`define PIC_EXT_CTRL    8'h4c
`define PIC_CORE_CTRL   8'h50
`define PIC_STATUS      8'h54
`define PIC_TIMED_IRQ_DISABLE_CNT    8'h58
`define PIC_SERVICE     8'h5c

// ----------------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------------
`define PIC_NEST_DIS_BIT 15
`define PIC_TIMED_IRQ_DISABLE_BIT     14
`define PIC_ALT_VT_BIT   15
`define PIC_ADDR_ERR_BIT 3
`define PIC_NUM_SRC      48
`define PIC_NUM_PRIO_REG 12
`define PIC_TIMED_IRQ_DISABLE_LEVEL   4'h6
`define PIC_VEC_LO       24'h000004
`define PIC_VEC_HI       24'h0000fe
`define PIC_IVT_FIRST    24'h000014
`define PIC_ALTERNATE_VECTOR_TABLE_FIRST   24'h000094
`define PIC_RESP_OKAY    2'b00
`define PIC_RESP_SLVERR  2'b10

`endif

// ### verilog/pic_arbiter.v
`include "pic_consts.vh"
`default_nettype none

// ----------------------------------------------------------------------
// Priority arbiter: highest assigned level wins, lower number breaks ties
// ----------------------------------------------------------------------
module pic_arbiter #(
  parameter NSRC = 48
) (
  // Requests and priorities
  input  wire [NSRC-1:0]   req,
  input  wire [4*NSRC-1:0] prio,
  // Result
  output reg               found,
  output reg  [5:0]        win_id,
  output reg  [2:0]        win_prio
);

  integer i;
  reg [2:0] p;

  always @* begin
    found    = 1'b0;
    win_id   = 6'h00;
    win_prio = 3'h0;
    p        = 3'h0;
    // Scanning downward with >= lets the lowest number win a tie.
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      p = prio[4*i +: 3];
      if (req[i] && (p != 3'h0) && (p >= win_prio)) begin
        found    = 1'b1;
        win_id   = i[5:0];
        win_prio = p;
      end
    end
  end

endmodule

`default_nettype wire

// ### verilog/pic_top.v
`include "pic_consts.vh"
`default_nettype none

module pic_top #(
  parameter NSRC = `PIC_NUM_SRC
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst_b,
  // Source events and traps, same clock domain
  input  wire [NSRC-1:0]   src_event,
  input  wire [3:0]        trap_event,
  // Core side
  input  wire              timed_irq_disable_start,
  input  wire [13:0]       timed_irq_disable_count,
  input  wire              instr_retire,
  input  wire              irq_ack,
  input  wire              irq_return,
  input  wire              fetch_valid,
  input  wire [23:0]       fetch_addr,
  input  wire              fetch_is_vector,
  input  wire              jump_valid,
  input  wire [23:0]       jump_target,
  input  wire [23:0]       prog_data,
  input  wire [23:0]       pc_seq,
  output reg               irq_req,
  output reg  [5:0]        irq_id,
  output reg  [23:0]       vector_addr,
  output reg  [23:0]       pc_next,
  output reg               addr_err_trap,
  // AXI4-Lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [NSRC-1:0]   flag_reg;
  reg [NSRC-1:0]   enable_reg;
  reg [4*NSRC-1:0] prio_reg;
  reg [15:0]       exc_ctrl_reg;
  reg [15:0]       ext_ctrl_reg;
  reg              ipl_hi_reg;
  reg [2:0]        ipl_lo_reg;
  reg [13:0]       timed_irq_disable_cnt_reg;
  reg              in_service_reg;
  reg [7:0]        aw_reg;
  reg [31:0]       wd_reg;
  reg [3:0]        ws_reg;
  reg              aw_have_reg;
  reg              w_have_reg;
  reg [2:0]        irq_id_prio;

  wire [3:0] cpu_level = {ipl_hi_reg, ipl_lo_reg};
  wire       nest_dis  = exc_ctrl_reg[`PIC_NEST_DIS_BIT];
  wire       timed_irq_disable_on   = (timed_irq_disable_cnt_reg != 14'h0000);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function in_vec;
    input [23:0] a;
    begin
      in_vec = (a >= `PIC_VEC_LO) && (a <= `PIC_VEC_HI);
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 2; k = k + 1) begin
        if (st[k]) begin
          merge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------
  wire       arb_found;
  wire [5:0] arb_id;
  wire [2:0] arb_prio;

  pic_arbiter #(.NSRC(NSRC)) u_arb (
    .req      (flag_reg & enable_reg),
    .prio     (prio_reg),
    .found    (arb_found),
    .win_id   (arb_id),
    .win_prio (arb_prio)
  );

  wire [3:0] win_level = {1'b0, arb_prio};
  wire take = arb_found && (win_level > cpu_level)
              && !(nest_dis && in_service_reg)
              && !(timed_irq_disable_on && (win_level <= `PIC_TIMED_IRQ_DISABLE_LEVEL));

  // Vector slot: two program words per vector, alternate table selectable.
  wire [23:0] vec_base = ext_ctrl_reg[`PIC_ALT_VT_BIT] ? `PIC_ALTERNATE_VECTOR_TABLE_FIRST
                                                       : `PIC_IVT_FIRST;
  wire [23:0] vec_addr_now = vec_base + {17'h00000, arb_id, 1'b0};

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  wire       aw_hit  = s_axi_awvalid && s_axi_awready;
  wire       w_hit   = s_axi_wvalid && s_axi_wready;
  wire       aw_ok   = aw_have_reg || aw_hit;
  wire       w_ok    = w_have_reg || w_hit;
  wire [7:0] waddr   = aw_have_reg ? aw_reg : s_axi_awaddr;
  wire [31:0] wdata  = w_have_reg ? wd_reg : s_axi_wdata;
  wire [3:0] wstrb   = w_have_reg ? ws_reg : s_axi_wstrb;
  // Registers are 16 bits wide, so only the two low byte lanes matter.
  wire [15:0] wd16   = wdata[15:0];
  wire [1:0] ws2     = wstrb[1:0];
  wire       do_wr   = aw_ok && w_ok && !s_axi_bvalid;
  wire       wr_prio = (waddr >= `PIC_PRIO_BASE) && (waddr <= `PIC_PRIO_LAST);
  wire [3:0] wr_pidx = waddr[5:2] - 4'h6;
  wire       wr_map  = (waddr <= `PIC_SERVICE) && (waddr[1:0] == 2'b00);

  // Software writes a one to clear a flag; a set from the source wins.
  reg [NSRC-1:0] flag_clr;
  always @* begin
    flag_clr = {NSRC{1'b0}};
    if (do_wr) begin
      case (waddr)
        `PIC_FLAG_A: flag_clr[15:0]  = merge(16'h0000, wd16, ws2);
        `PIC_FLAG_B: flag_clr[31:16] = merge(16'h0000, wd16, ws2);
        `PIC_FLAG_C: flag_clr[NSRC-1:32] = merge(16'h0000, wd16, ws2);
        default:     flag_clr = {NSRC{1'b0}};
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      flag_reg       <= {NSRC{1'b0}};
      enable_reg     <= {NSRC{1'b0}};
      prio_reg       <= {4*NSRC{1'b0}};
      exc_ctrl_reg   <= 16'h0000;
      ext_ctrl_reg   <= 16'h0000;
      ipl_hi_reg     <= 1'b0;
      ipl_lo_reg     <= 3'h0;
      timed_irq_disable_cnt_reg   <= 14'h0000;
      in_service_reg <= 1'b0;
      aw_have_reg    <= 1'b0;
      w_have_reg     <= 1'b0;
      aw_reg         <= 8'h00;
      wd_reg         <= 32'h0;
      ws_reg         <= 4'h0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `PIC_RESP_OKAY;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | src_event;
      if (trap_event != 4'h0) begin
        exc_ctrl_reg[3:0] <= exc_ctrl_reg[3:0] | trap_event;
      end
      if (addr_err_trap) begin
        exc_ctrl_reg[`PIC_ADDR_ERR_BIT] <= 1'b1;
      end
      if (timed_irq_disable_start) begin
        timed_irq_disable_cnt_reg <= timed_irq_disable_count;
      end else if (timed_irq_disable_on && instr_retire) begin
        timed_irq_disable_cnt_reg <= timed_irq_disable_cnt_reg - 14'h0001;
      end
      if (irq_ack) begin
        in_service_reg <= 1'b1;
        ipl_hi_reg     <= 1'b0;
        ipl_lo_reg     <= irq_id_prio;
      end else if (irq_return) begin
        in_service_reg <= 1'b0;
      end
      s_axi_awready <= !aw_ok && !s_axi_awready;
      s_axi_wready  <= !w_ok && !s_axi_wready;
      if (aw_hit && !do_wr) begin
        aw_have_reg <= 1'b1;
        aw_reg      <= s_axi_awaddr;
      end
      if (w_hit && !do_wr) begin
        w_have_reg <= 1'b1;
        wd_reg     <= s_axi_wdata;
        ws_reg     <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        aw_have_reg   <= 1'b0;
        w_have_reg    <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_map ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
        if (wr_prio) begin
          // Bit 3 of each slot is forced to zero.
          prio_reg[16*wr_pidx +: 16] <= merge(16'h0000, wd16, ws2) & 16'h7777;
        end
        case (waddr)
          `PIC_EN_A:   enable_reg[15:0]  <= merge(enable_reg[15:0], wd16, ws2);
          `PIC_EN_B:   enable_reg[31:16] <= merge(enable_reg[31:16], wd16, ws2);
          `PIC_EN_C:   enable_reg[NSRC-1:32] <= merge(enable_reg[NSRC-1:32], wd16, ws2);
          // A trap or address error in the cycle of the write still sets its bit.
          `PIC_EXC_CTRL: exc_ctrl_reg <= merge(exc_ctrl_reg, wd16, ws2)
                                         | {12'h000, trap_event | {addr_err_trap, 3'h0}};
          `PIC_EXT_CTRL: ext_ctrl_reg[15] <= wstrb[1] ? wdata[15] : ext_ctrl_reg[15];
          `PIC_CORE_CTRL: if (!nest_dis && wstrb[0]) ipl_hi_reg <= wdata[3];
          `PIC_STATUS:    if (!nest_dis && wstrb[0]) ipl_lo_reg <= wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Priority of the request being acknowledged raises the CPU level.
  always @* begin
    irq_id_prio = prio_reg[4*irq_id +: 3];
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  wire [3:0] rd_pidx = s_axi_araddr[5:2] - 4'h6;
  reg  [31:0] rd_val;
  always @* begin
    rd_val = 32'h0;
    if ((s_axi_araddr >= `PIC_PRIO_BASE) && (s_axi_araddr <= `PIC_PRIO_LAST)) begin
      rd_val = {16'h0, prio_reg[16*rd_pidx +: 16]};
    end else begin
      case (s_axi_araddr)
        `PIC_FLAG_A:    rd_val = {16'h0, flag_reg[15:0]};
        `PIC_FLAG_B:    rd_val = {16'h0, flag_reg[31:16]};
        `PIC_FLAG_C:    rd_val = {16'h0, flag_reg[NSRC-1:32]};
        `PIC_EN_A:      rd_val = {16'h0, enable_reg[15:0]};
        `PIC_EN_B:      rd_val = {16'h0, enable_reg[31:16]};
        `PIC_EN_C:      rd_val = {16'h0, enable_reg[NSRC-1:32]};
        `PIC_EXC_CTRL:  rd_val = {16'h0, exc_ctrl_reg};
        `PIC_EXT_CTRL:  rd_val = {16'h0, ext_ctrl_reg[15], timed_irq_disable_on, 14'h0};
        `PIC_CORE_CTRL: rd_val = {28'h0, ipl_hi_reg, 3'h0};
        `PIC_STATUS:    rd_val = {29'h0, ipl_lo_reg};
        `PIC_TIMED_IRQ_DISABLE_CNT:  rd_val = {18'h0, timed_irq_disable_cnt_reg};
        `PIC_SERVICE:   rd_val = {24'h0, in_service_reg, 1'b0, irq_id};
        default:        rd_val = 32'h0;
      endcase
    end
  end
  wire rd_map = (s_axi_araddr <= `PIC_SERVICE) && (s_axi_araddr[1:0] == 2'b00);

  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `PIC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_map ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Core outputs: request, vector, program counter mux, address errors
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_req       <= 1'b0;
      irq_id        <= 6'h00;
      vector_addr   <= 24'h0;
      pc_next       <= 24'h0;
      addr_err_trap <= 1'b0;
    end else begin
      irq_req     <= take && !irq_ack;
      irq_id      <= arb_id;
      vector_addr <= vec_addr_now;
      pc_next     <= fetch_is_vector ? prog_data : pc_seq;
      // Vector words are reached only by the vector fetch itself.
      addr_err_trap <= (fetch_valid && !fetch_is_vector && in_vec(fetch_addr))
                       || (jump_valid && in_vec(jump_target));
    end
  end

endmodule

`default_nettype wire

// ### test/pic_props.sv
`include "pic_consts.vh"
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the interrupt controller
// ----------------------------------------------------------------------
module pic_props #(
  parameter NSRC = 48
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Fetch and jump watch
  input wire logic        fetch_valid,
  input wire logic [23:0] fetch_addr,
  input wire logic        fetch_is_vector,
  input wire logic        jump_valid,
  input wire logic [23:0] jump_target,
  input wire logic [23:0] prog_data,
  input wire logic [23:0] pc_next,
  input wire logic        addr_err_trap,
  // Request to the core
  input wire logic        irq_req,
  input wire logic [5:0]  irq_id,
  input wire logic [23:0] vector_addr,
  // Bus responses
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [23:0] voff = {17'h0, irq_id, 1'b0};
  wire logic        bad_f = fetch_valid && !fetch_is_vector && fetch_addr >= `PIC_VEC_LO
                            && fetch_addr <= `PIC_VEC_HI;
  wire logic        bad_j = jump_valid && jump_target >= `PIC_VEC_LO
                            && jump_target <= `PIC_VEC_HI;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  vec_word_a: assert property (fetch_is_vector |=> pc_next == $past(prog_data))
    else $error("vector word not loaded");
  fetch_err_a: assert property (bad_f |=> addr_err_trap)
    else $error("vector fetch not trapped");
  jump_err_a: assert property (bad_j |=> addr_err_trap)
    else $error("vector jump not trapped");
  no_false_trap_a: assert property (!bad_f && !bad_j |=> !addr_err_trap)
    else $error("spurious address trap");
  vec_addr_a: assert property (irq_req |-> vector_addr == `PIC_IVT_FIRST + voff
    || vector_addr == `PIC_ALTERNATE_VECTOR_TABLE_FIRST + voff) else $error("vector address wrong");
  id_range_a: assert property (irq_req |-> irq_id < NSRC)
    else $error("winner out of range");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule

bind pic_top pic_props #(.NSRC(NSRC)) u_props (.*);
`default_nettype wire

// ### test/pic_core_model.sv
`default_nettype none
// ----------------------------------------------------------------------
// Core model: takes requests when allowed, retires every other cycle
// ----------------------------------------------------------------------
module pic_core_model (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst_b,
  // Bench control and controller request
  input wire logic  irq_req,
  input wire logic  accept,
  input wire logic  ret,
  // Core answers
  output var logic  irq_ack,
  output var logic  irq_return,
  output var logic  instr_retire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_reg;
  // A second take is held off until return, as a real core would.
  always @(posedge clk) begin
    if (!rst_b) begin
      {irq_ack, irq_return, instr_retire, busy_reg} <= 4'h0;
    end else begin
      irq_ack <= accept && irq_req && !busy_reg && !irq_ack;
      busy_reg <= (busy_reg || irq_ack) && !ret;
      irq_return <= ret && busy_reg;
      instr_retire <= !instr_retire;
    end
  end
endmodule
`default_nettype wire

// ### test/testbench.sv
`include "pic_consts.vh"
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for the interrupt controller
// ----------------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, timed_irq_disable_start, instr_retire, irq_ack, irq_return, accept, ret;
  logic        fetch_valid, fetch_is_vector, jump_valid, irq_req, addr_err_trap;
  logic [47:0] src_event;
  logic [3:0]  trap_event, s_axi_wstrb;
  logic [13:0] timed_irq_disable_count;
  logic [23:0] fetch_addr, jump_target, prog_data, pc_seq, vector_addr, pc_next;
  logic [5:0]  irq_id;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          fails = 0, tests_run = 0, cycles = 0;
  pic_top DUT (.*);
  pic_core_model core (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The ceiling of 20000 cycles is some sixty times the run, so only a hang reaches it.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic close_out;
    $display("compared %0d, mismatched %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ev(input logic [47:0] m);
    @(posedge clk);
    src_event <= m;
    @(posedge clk);
    src_event <= 48'h0;
  endtask
  // Each channel is released at the edge that takes it; bready and rready stand from the start.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rdat, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic probe(input logic fv, iv, jv, input logic [23:0] a, input logic e);
    @(posedge clk);
    {fetch_valid, fetch_is_vector, jump_valid, fetch_addr, jump_target} <= {fv, iv, jv, a, a};
    @(posedge clk);
    {fetch_valid, jump_valid} <= 2'b00;
    @(negedge clk);
    chk({31'h0, addr_err_trap}, {31'h0, e});
    chk({8'h0, pc_next}, {8'h0, iv ? prog_data : pc_seq});
  endtask
  task automatic s_flags;
    ev(48'h0100_0000_0020);
    idle(3);
    chk({31'h0, irq_req}, 32'h0);
    rd(`PIC_FLAG_A);
    chk(rdat, 32'h20);
    rd(`PIC_FLAG_C);
    chk(rdat, 32'h100);
    wr(`PIC_FLAG_A, 32'h20);
    chk({30'h0, rsp}, 32'h0);
    rd(`PIC_FLAG_A);
    chk(rdat, 32'h0);
    $display("flags test done");
  endtask
  task automatic s_prio;
    wr(`PIC_PRIO_BASE, 32'hffff);
    rd(`PIC_PRIO_BASE);
    chk(rdat, 32'h7777);
    wr(`PIC_PRIO_BASE, 32'h0440);
    wr(`PIC_FLAG_A, 32'hffff);
    wr(`PIC_EN_A, 32'h020f);
    ev(48'hf);
    idle(3);
    chk({26'h0, irq_id}, 32'h1);
    chk({8'h0, vector_addr}, 32'h16);
    wr(`PIC_EXT_CTRL, 32'h8000);
    idle(2);
    chk({8'h0, vector_addr}, 32'h96);
    wr(`PIC_EXT_CTRL, 32'h0);
    wr(`PIC_STATUS, 32'h4);
    idle(3);
    chk({31'h0, irq_req}, 32'h0);
    wr(`PIC_PRIO_BASE + 8'h08, 32'h0050);
    ev(48'h200);
    idle(3);
    chk({26'h0, irq_id}, 32'h9);
    wr(`PIC_CORE_CTRL, 32'h8);
    idle(3);
    chk({31'h0, irq_req}, 32'h0);
    wr(`PIC_CORE_CTRL, 32'h0);
    wr(`PIC_STATUS, 32'h0);
    $display("priority test done");
  endtask
  task automatic s_nest;
    wr(`PIC_EXC_CTRL, 32'h8000);
    wr(`PIC_STATUS, 32'h3);
    rd(`PIC_STATUS);
    chk(rdat, 32'h0);
    @(posedge clk);
    accept <= 1'b1;
    do @(negedge clk); while (!irq_ack);
    @(posedge clk);
    accept <= 1'b0;
    wr(`PIC_PRIO_BASE + 8'h08, 32'h0750);
    wr(`PIC_EN_A, 32'h060f);
    ev(48'h400);
    idle(3);
    chk({31'h0, irq_req}, 32'h0);
    rd(`PIC_SERVICE);
    chk(rdat, 32'h8a);
    wr(`PIC_EXC_CTRL, 32'h0);
    idle(3);
    chk({25'h0, irq_req, irq_id}, 32'h4a);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    $display("nesting test done");
  endtask
  task automatic s_timed_irq_disable;
    @(posedge clk);
    trap_event <= 4'h4;
    @(posedge clk);
    trap_event <= 4'h0;
    rd(`PIC_EXC_CTRL);
    chk(rdat, 32'h4);
    wr(`PIC_PRIO_BASE, 32'h0076);
    wr(`PIC_EN_A, 32'h3);
    @(posedge clk);
    {timed_irq_disable_count, timed_irq_disable_start} <= {14'd30, 1'b1};
    @(posedge clk);
    timed_irq_disable_start <= 1'b0;
    ev(48'h1);
    idle(3);
    chk({31'h0, irq_req}, 32'h0);
    rd(`PIC_EXT_CTRL);
    chk(rdat & 32'h4000, 32'h4000);
    ev(48'h2);
    idle(3);
    chk({25'h0, irq_req, irq_id}, 32'h41);
    idle(80);
    rd(`PIC_EXT_CTRL);
    chk(rdat & 32'h4000, 32'h0);
    $display("timed disable test done");
  endtask
  task automatic s_addr;
    probe(1'b1, 1'b0, 1'b0, 24'h000004, 1'b1);
    probe(1'b1, 1'b0, 1'b0, 24'h000100, 1'b0);
    probe(1'b1, 1'b1, 1'b0, 24'h0000fe, 1'b0);
    probe(1'b0, 1'b0, 1'b1, 24'h0000fe, 1'b1);
    probe(1'b0, 1'b0, 1'b1, 24'h000100, 1'b0);
    rd(`PIC_EXC_CTRL);
    chk(rdat & 32'h8, 32'h8);
    rd(8'h60);
    chk({rdat[29:0], rsp}, 32'h2);
    wr(8'h62, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    $display("address error test done");
  endtask
  initial begin
    {rst_b, src_event, trap_event, timed_irq_disable_start, timed_irq_disable_count} <= '0;
    {fetch_valid, fetch_is_vector, jump_valid, fetch_addr, jump_target, accept, ret} <= '0;
    {prog_data, pc_seq, s_axi_wstrb} <= {24'h123456, 24'h000200, 4'hf};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
    do_reset();
    s_flags();
    s_prio();
    s_nest();
    do_reset();
    s_timed_irq_disable();
    s_addr();
    close_out();
  end
endmodule
`default_nettype wire
